// ===== src/gtm_pkg.sv
package gtm_pkg;

  // Bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_AMR   = 8'h04;
  localparam logic [7:0] OFS_BMR   = 8'h08;
  localparam logic [7:0] OFS_CTL   = 8'h0C;
  localparam logic [7:0] OFS_IMR   = 8'h18;
  localparam logic [7:0] OFS_RIS   = 8'h1C;
  localparam logic [7:0] OFS_MIS   = 8'h20;
  localparam logic [7:0] OFS_ICR   = 8'h24;
  localparam logic [7:0] OFS_AILR  = 8'h28;
  localparam logic [7:0] OFS_BILR  = 8'h2C;
  localparam logic [7:0] OFS_AMTCH = 8'h30;
  localparam logic [7:0] OFS_BMTCH = 8'h34;
  localparam logic [7:0] OFS_APR   = 8'h38;
  localparam logic [7:0] OFS_BPR   = 8'h3C;
  localparam logic [7:0] OFS_ACNT  = 8'h48;
  localparam logic [7:0] OFS_BCNT  = 8'h4C;

  // Global arrangement codes
  localparam logic [2:0] CFG_32  = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16  = 3'h4;

  // Mode field codes
  localparam logic [1:0] MR_ONESHOT = 2'h1;
  localparam logic [1:0] MR_PERIOD  = 2'h2;
  localparam logic [1:0] MR_CAPT    = 2'h3;

  // Edge event encodings
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;

  // Control bit positions for the first half; the second half sits HALF_SH higher
  localparam int HALF_SH   = 8;
  localparam int CTL_EN    = 0;
  localparam int CTL_EV_LO = 2;
  localparam int CTL_RUN   = 4;
  localparam int CTL_PWML  = 6;

  // Status bit positions for the first half, same stride
  localparam int ST_TO  = 0;
  localparam int ST_CM  = 1;
  localparam int ST_CE  = 2;
  localparam int ST_RTC = 3;

  // Reset values
  localparam logic [31:0] LOAD32_RST = 32'hFFFFFFFF;
  localparam logic [15:0] LOAD16_RST = 16'hFFFF;
  localparam logic [31:0] RTC_START  = 32'h00000001;

  // Timing: external slow clock and the tick rate it is divided to
  localparam int RTC_IN_HZ   = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV     = RTC_IN_HZ / RTC_TICK_HZ;
  localparam int DIV_W       = 16;

  // Whole state of the timer
  typedef struct packed {
    logic [2:0]        cfg;
    logic [1:0][3:0]   mode;
    logic [15:0]       ctl;
    logic [15:0]       imr;
    logic [15:0]       ris;
    logic [31:0]       ila;
    logic [15:0]       ilb;
    logic [31:0]       mta;
    logic [15:0]       mtb;
    logic [1:0][7:0]   pr;
    logic [1:0][7:0]   psc;
    logic [1:0][15:0]  cnt;
    logic [1:0][15:0]  cap;
    logic [1:0]        ccp_d;
    logic [1:0]        pwm_raw;
    logic [1:0]        pwm_out;
    logic [1:0]        pwm_oe;
    logic [DIV_W-1:0]  div;
    logic [31:0]       rdata;
  } gtm_state_t;

  localparam gtm_state_t STATE_RST = '{ila: LOAD32_RST, ilb: LOAD16_RST, mta: LOAD32_RST, mtb: LOAD16_RST,
                                       cnt: {LOAD16_RST, LOAD16_RST}, default: '0};

endpackage

// ===== src/gtm_timer.sv
// Function
// - Edge-time half free-runs down, reloads at zero
// - Edge-time: capture select 1, mode 3
// - Edge copies count, sets edge-time flag
// - Captured count holds until next edge
// - Prescaler ignored in edge-time and PWM
// - PWM: alternate 1, capture 0, mode 2
// - PWM counts down, reloads, repeats while enabled
// - PWM half never sets status flags
// - PWM high at load, low at match
// - Output-level bit inverts PWM output
// - Load write takes effect next cycle
// - Config 0 32-bit, 1 RTC, 4 split
// - Mode 1 one-shot, 2 periodic
// - One-shot stops on time-out, periodic continues
// - Prescaler extends 16-bit one-shot/periodic
// - Time-out flag set, cleared by writing one
// - RTC match sets flag, keeps counting
// - Edge-count: capture select 0, mode 3
// - Edge-count stops at target, sets match
// - Each selected edge decrements; match reloads, disables
// - One-shot reloads at zero, clears enable
// - Slow clock divided to one-second tick
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module gtm_timer #(
  parameter int RTC_DIVIDE = gtm_pkg::RTC_DIV  // Slow clock edges per counter tick
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // Register port
  input  wire logic [gtm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [gtm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [gtm_pkg::DATA_W-1:0]  rdata,
  // Capture/compare pins, one per half
  input  wire logic [1:0]                  ccp_in,
  output logic      [1:0]                  ccp_out,
  output logic      [1:0]                  ccp_oe
);
  import gtm_pkg::*;

  // Divider must fit its counter and divide by at least two
  if (RTC_DIVIDE < 2 || RTC_DIVIDE > (1 << DIV_W)) begin : g_bad_div
    $error("RTC_DIVIDE out of range");
  end

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIVIDE - 1);

  logic       rst_meta_r;   // Reset release, first stage
  logic       rst_sync_r;   // Reset release seen by the design
  gtm_state_t q_r;          // Registered state
  gtm_state_t q_nxt;        // Next state

  // Selected edge decode, shared by both capture modes
  function automatic logic edge_hit(input logic [1:0] ev, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    unique case (ev)
      EV_RISE: edge_hit = rise;
      EV_FALL: edge_hit = fall;
      EV_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;                  // Reserved code catches nothing
    endcase
  endfunction

  // Reset is removed in step with the clock to keep release away from edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Next-state logic for both halves, the joined counter and the register port
  always_comb begin
    logic [15:0] set;     // Status events raised this cycle
    logic [15:0] clr;     // Status bits cleared by software
    logic [1:0]  mr;      // Mode field of a half
    logic        cmr;     // Capture mode select of a half
    logic        ams;     // Alternate mode select of a half
    logic        en;      // Half enable
    logic        hit;     // Selected edge seen
    logic        pwm;     // Half is in PWM mode
    logic [15:0] il;      // Interval load of a half
    logic [15:0] mt;      // Match value of a half
    logic [15:0] dec;     // Count less one
    logic [31:0] c32;     // Joined counter
    logic        split;   // Halves run independently
    set   = '0;
    clr   = '0;
    mr    = '0;
    cmr   = 1'b0;
    ams   = 1'b0;
    en    = 1'b0;
    hit   = 1'b0;
    pwm   = 1'b0;
    il    = '0;
    mt    = '0;
    dec   = '0;
    c32   = '0;
    split = q_r.cfg[2];
    q_nxt = q_r;
    q_nxt.rdata = '0;                            // Read data stands one cycle only
    q_nxt.ccp_d = ccp_in;

    // Independent halves
    for (int i = 0; i < 2; i++) begin
      mr  = q_r.mode[i][1:0];
      cmr = q_r.mode[i][2];
      ams = q_r.mode[i][3];
      en  = q_r.ctl[CTL_EN + HALF_SH*i];
      hit = edge_hit(q_r.ctl[CTL_EV_LO + HALF_SH*i +: 2], ccp_in[i], q_r.ccp_d[i]);
      il  = (i == 0) ? q_r.ila[15:0] : q_r.ilb;
      mt  = (i == 0) ? q_r.mta[15:0] : q_r.mtb;
      dec = q_r.cnt[i] - 16'h0001;
      pwm = split && ams && !cmr && (mr == MR_PERIOD);
      q_nxt.pwm_oe[i] = pwm;                     // Pin driven whenever the half is in PWM mode, enabled or not
      if (split && en) begin
        if (pwm) begin
          // Plain down count, prescaler left alone, no status
          q_nxt.cnt[i] = (q_r.cnt[i] == 16'h0000) ? il : dec;
          if (q_r.cnt[i] == il) begin
            q_nxt.pwm_raw[i] = 1'b1;
          end else if (q_r.cnt[i] == mt) begin
            q_nxt.pwm_raw[i] = 1'b0;
          end
        end else if (mr == MR_CAPT && cmr) begin
          // Edge time: free-running, capture does not stop the count
          q_nxt.cnt[i] = (q_r.cnt[i] == 16'h0000) ? il : dec;
          if (hit) begin
            q_nxt.cap[i] = q_r.cnt[i];
            set[ST_CE + HALF_SH*i] = 1'b1;
          end
        end else if (mr == MR_CAPT) begin
          // Edge count: only selected edges move the counter
          if (hit) begin
            if (dec == mt) begin
              q_nxt.cnt[i] = il;
              set[ST_CM + HALF_SH*i] = 1'b1;
              q_nxt.ctl[CTL_EN + HALF_SH*i] = 1'b0;
            end else begin
              q_nxt.cnt[i] = dec;
            end
          end
        end else if (mr == MR_ONESHOT || mr == MR_PERIOD) begin
          if (q_r.cnt[i] == 16'h0000) begin
            // Time-out: reload count and prescale together
            q_nxt.cnt[i] = il;
            q_nxt.psc[i] = q_r.pr[i];
            set[ST_TO + HALF_SH*i] = 1'b1;
            if (mr == MR_ONESHOT) begin
              q_nxt.ctl[CTL_EN + HALF_SH*i] = 1'b0;
            end
          end else if (q_r.psc[i] == 8'h00) begin
            q_nxt.psc[i] = q_r.pr[i];
            q_nxt.cnt[i] = dec;
          end else begin
            q_nxt.psc[i] = q_r.psc[i] - 8'h01;
          end
        end
      end
      q_nxt.pwm_out[i] = q_nxt.pwm_raw[i] ^ q_r.ctl[CTL_PWML + HALF_SH*i];
    end

    // Joined 32-bit counter, first half controls
    c32 = q_r.cnt;
    mr  = q_r.mode[0][1:0];
    en  = q_r.ctl[CTL_EN];
    if (q_r.cfg == CFG_32 && en && (mr == MR_ONESHOT || mr == MR_PERIOD)) begin
      if (c32 == 32'h00000000) begin
        q_nxt.cnt = q_r.ila;
        set[ST_TO] = 1'b1;
        if (mr == MR_ONESHOT) begin
          q_nxt.ctl[CTL_EN] = 1'b0;
        end
      end else begin
        q_nxt.cnt = c32 - 32'h00000001;
      end
    end else if (q_r.cfg == CFG_RTC && en) begin
      // Slow clock sampled on the even pin; its rising edges feed the divider
      if (ccp_in[0] && !q_r.ccp_d[0]) begin
        if (q_r.div == DIV_LAST) begin
          q_nxt.div = '0;
          if (c32 == q_r.mta) begin
            q_nxt.cnt = 32'h00000000;
            set[ST_RTC] = 1'b1;
          end else begin
            q_nxt.cnt = c32 + 32'h00000001;
          end
        end else begin
          q_nxt.div = q_r.div + DIV_W'(1);
        end
      end
    end

    // Status: an event in the clearing cycle survives
    if (wr_en && addr == OFS_ICR) begin
      clr = wdata[15:0];
    end
    q_nxt.ris = (q_r.ris & ~clr) | set;

    // Software writes; a control write overrides a hardware enable clear
    if (wr_en) begin
      unique case (addr)
        OFS_CFG: begin
          q_nxt.cfg = wdata[2:0];
          if (wdata[2:0] == CFG_RTC) begin
            q_nxt.cnt = RTC_START;               // Counter starts from one
            q_nxt.div = '0;
          end
        end
        OFS_AMR:   q_nxt.mode[0] = wdata[3:0];
        OFS_BMR:   q_nxt.mode[1] = wdata[3:0];
        OFS_CTL:   q_nxt.ctl = wdata[15:0];
        OFS_IMR:   q_nxt.imr = wdata[15:0];
        OFS_AILR: begin
          q_nxt.ila = wdata;
          // New load enters the counter on the next cycle
          if (split) begin
            q_nxt.cnt[0] = wdata[15:0];
          end else begin
            q_nxt.cnt = wdata;
          end
        end
        OFS_BILR: begin
          q_nxt.ilb = wdata[15:0];
          if (split) begin
            q_nxt.cnt[1] = wdata[15:0];
          end
        end
        OFS_AMTCH: q_nxt.mta = wdata;
        OFS_BMTCH: q_nxt.mtb = wdata[15:0];
        OFS_APR:   q_nxt.pr[0] = wdata[7:0];
        OFS_BPR:   q_nxt.pr[1] = wdata[7:0];
        default: ;                               // Other offsets ignore writes
      endcase
    end

    // Read path; unmapped offsets read zero
    if (rd_en) begin
      unique case (addr)
        OFS_CFG:   q_nxt.rdata = {29'h0, q_r.cfg};
        OFS_AMR:   q_nxt.rdata = {28'h0, q_r.mode[0]};
        OFS_BMR:   q_nxt.rdata = {28'h0, q_r.mode[1]};
        OFS_CTL:   q_nxt.rdata = {16'h0, q_r.ctl};
        OFS_IMR:   q_nxt.rdata = {16'h0, q_r.imr};
        OFS_RIS:   q_nxt.rdata = {16'h0, q_r.ris};
        OFS_MIS:   q_nxt.rdata = {16'h0, q_r.ris & q_r.imr};
        OFS_AILR:  q_nxt.rdata = q_r.ila;
        OFS_BILR:  q_nxt.rdata = {16'h0, q_r.ilb};
        OFS_AMTCH: q_nxt.rdata = q_r.mta;
        OFS_BMTCH: q_nxt.rdata = {16'h0, q_r.mtb};
        OFS_APR:   q_nxt.rdata = {24'h0, q_r.pr[0]};
        OFS_BPR:   q_nxt.rdata = {24'h0, q_r.pr[1]};
        OFS_ACNT: begin
          if (!split) begin
            q_nxt.rdata = q_r.cnt;
          end else if (q_r.mode[0][2:0] == {1'b1, MR_CAPT}) begin
            q_nxt.rdata = {16'h0, q_r.cap[0]};
          end else begin
            q_nxt.rdata = {16'h0, q_r.cnt[0]};
          end
        end
        OFS_BCNT: begin
          if (q_r.mode[1][2:0] == {1'b1, MR_CAPT}) begin
            q_nxt.rdata = {16'h0, q_r.cap[1]};
          end else begin
            q_nxt.rdata = {16'h0, q_r.cnt[1]};
          end
        end
        default:   q_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      q_r <= STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign rdata   = q_r.rdata;
  assign ccp_out = q_r.pwm_out;
  assign ccp_oe  = q_r.pwm_oe;

endmodule // gtm_timer

// ===== test/gtm_pin_src.sv
`timescale 1ns/10ps
// Far-side source on the capture pins
module gtm_pin_src (
  // Clock
  input wire logic       clk_sys,
  // Levels offered to the pins
  output logic     [1:0] lvl
);
  initial lvl = 2'b00;
  // One level change held three cycles so each edge is seen once
  task automatic step(input int h, input logic v);
    lvl[h] <= v;
    repeat (3) @(posedge clk_sys);
  endtask
  // Whole low-high cycles; on pin 0 this is the slow clock, still between bursts
  task automatic pulses(input int h, input int n);
    repeat (n) begin
      step(h, 1'b1);
      step(h, 1'b0);
    end
  endtask
endmodule // gtm_pin_src

// ===== test/gtm_timer_assertions.sv
`timescale 1ns/10ps
// Port-level checks; sees nothing inside the timer
module gtm_timer_chk #(
  parameter int RTC_DIVIDE = 4  // Slow edges per tick
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  // Pins
  input wire logic [1:0]  ccp_in,
  input wire logic [1:0]  ccp_out,
  input wire logic [1:0]  ccp_oe
);
  import gtm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Read data only in its one slot
  property p_rd_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
  property p_cfg_rb; wr_en && addr == OFS_CFG ##1 rd_en && addr == OFS_CFG |=> rdata == {29'h0, $past(wdata[2:0], 2)};
  endproperty
  a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
  // Mode field is four bits wide
  property p_mode_w; rd_en && addr == OFS_AMR |=> rdata[31:4] == 28'h0; endproperty
  a_mode_w: assert property (p_mode_w) else $error("mode high bits set");
  // Pin drive only moves after a register write
  property p_oe_cause; $changed(ccp_oe) |-> $past(wr_en) || $past(wr_en, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
  property p_oe_off; wr_en && addr == OFS_AMR && wdata[3:0] != 4'hA |-> ##[1:2] !ccp_oe[0]; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven outside waveform mode");
  // Prescaler is eight bits
  property p_pr_w; rd_en && addr == OFS_APR |=> rdata[31:8] == 24'h0; endproperty
  a_pr_w: assert property (p_pr_w) else $error("prescale high bits set");
  property p_cnt_b; rd_en && addr == OFS_BCNT |=> rdata[31:16] == 16'h0; endproperty
  a_cnt_b: assert property (p_cnt_b) else $error("half count too wide");
  property p_ilb_rb; wr_en && addr == OFS_BILR ##1 rd_en && addr == OFS_BILR |=> rdata == {16'h0, $past(wdata[15:0], 2)};
  endproperty
  a_ilb_rb: assert property (p_ilb_rb) else $error("load readback wrong");
endmodule // gtm_timer_chk

// ===== test/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; $display("Error %0t got %h exp %h", $time, a, e); end end
bind gtm_timer gtm_timer_chk #(.RTC_DIVIDE(RTC_DIVIDE)) CHK (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe));
module testbench;
  import gtm_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] e; } gtm_row_t;
  logic        clk_sys;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic [1:0]  ccp_out;
  logic [1:0]  ccp_oe;
  logic [1:0]  src_lvl;  // Far-side drive
  logic [1:0]  pin_w;    // Resolved pin level
  logic [31:0] d;        // Last read word
  logic [31:0] d0;       // Earlier read word
  int          err_total;
  int          checked;
  logic [31:0] hi;       // High-cycle count; four-state so an unknown output level shows up
  // Reset values, with an unmapped hole at the end
  gtm_row_t rows [16] = '{'{OFS_CFG, 32'h0}, '{OFS_AMR, 32'h0}, '{OFS_BMR, 32'h0}, '{OFS_CTL, 32'h0},
    '{OFS_IMR, 32'h0}, '{OFS_RIS, 32'h0}, '{OFS_MIS, 32'h0}, '{OFS_AILR, LOAD32_RST}, '{OFS_BILR, 32'hFFFF},
    '{OFS_AMTCH, LOAD32_RST}, '{OFS_BMTCH, 32'hFFFF}, '{OFS_APR, 32'h0}, '{OFS_BPR, 32'h0},
    '{OFS_ACNT, LOAD32_RST}, '{OFS_BCNT, 32'hFFFF}, '{8'h10, 32'h0}};
  // The timer drives a pin while the half is in PWM mode, the source otherwise
  assign pin_w = (ccp_oe & ccp_out) | (~ccp_oe & src_lvl);
  gtm_timer #(.RTC_DIVIDE(4)) DUT (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ccp_in(pin_w), .ccp_out(ccp_out), .ccp_oe(ccp_oe));
  gtm_pin_src SRC (.clk_sys(clk_sys), .lvl(src_lvl));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Bus tasks start and end on a rising edge so strobes chain back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys);
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bounded wait for a status bit; slow adds clock bursts on pin 0
  task automatic poll(input int b, input bit slow);
    d = 32'h0;
    for (int i = 0; i < 60 && d[b] !== 1'b1; i++) begin
      if (slow) SRC.pulses(0, 2);
      rd(OFS_RIS);
    end
    `CHK(d[b], 1'b1)
    if (d[b] !== 1'b1) summarize();
  endtask
  // Waveform high cycles over twenty cycles, after settling
  task automatic duty(input int e);
    repeat (10) @(posedge clk_sys);
    hi = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 hi += ccp_out[0];
    end
    @(posedge clk_sys);
    `CHK(hi, e)
  endtask
  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_total = 0;
    checked = 0;
    do_reset();
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK(d, rows[i].e)
    end
    // Split arrangement; status is read-only
    wr(OFS_CFG, {29'h0, CFG_16});
    rd(OFS_CFG);
    `CHK(d[2:0], CFG_16)
    wr(OFS_RIS, 32'hFFFF);
    rd(OFS_RIS);
    `CHK(d, 32'h0)
    // One-shot on half B stops, reloads and drops its enable
    wr(OFS_BMR, {30'h0, MR_ONESHOT});
    wr(OFS_BILR, 32'h5);
    rd(OFS_BILR);
    wr(OFS_IMR, 32'h100);
    wr(OFS_CTL, 32'h100);
    poll(8, 0);
    rd(OFS_MIS);
    `CHK(d, 32'h100)
    rd(OFS_CTL);
    `CHK(d[8], 1'b0)
    wr(OFS_ICR, 32'h100);
    rd(OFS_RIS);
    `CHK(d, 32'h0)
    // Periodic half A with prescale 1: one step per two cycles
    wr(OFS_AMR, {30'h0, MR_PERIOD});
    wr(OFS_APR, 32'h1);
    wr(OFS_CTL, 32'h1);
    rd(OFS_ACNT);
    d0 = d;
    rd(OFS_ACNT);
    `CHK(d, d0 - 32'h1)
    wr(OFS_AILR, 32'h3);
    poll(0, 0);
    wr(OFS_ICR, 32'h1);
    poll(0, 0);
    rd(OFS_CTL);
    `CHK(d[0], 1'b1)
    rd(OFS_BCNT);
    `CHK(d, 32'h5)
    wr(OFS_CTL, 32'h0);
    // Edge time on half A: capture holds, later edge gives a lower count
    wr(OFS_AMR, 32'h7);
    wr(OFS_AILR, 32'hFFFF);
    wr(OFS_CTL, 32'h1);
    SRC.step(0, 1'b1);
    rd(OFS_ACNT);
    d0 = d;
    SRC.step(0, 1'b0);
    rd(OFS_ACNT);
    `CHK(d, d0)
    SRC.step(0, 1'b1);
    rd(OFS_ACNT);
    `CHK(d < d0, 1'b1)
    SRC.step(0, 1'b0);
    // Every event code, reserved included
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTL, 32'h0);
      wr(OFS_ICR, 32'h4);
      wr(OFS_CTL, 32'h1 | (k << 2));
      SRC.step(0, 1'b1);
      rd(OFS_RIS);
      `CHK(d[2], 4'b1001 >> k & 1'b1)
      wr(OFS_ICR, 32'h4);
      SRC.step(0, 1'b0);
      rd(OFS_RIS);
      `CHK(d[2], 4'b1010 >> k & 1'b1)
    end
    // Edge count on half B: ten down to six is four edges, both kinds
    wr(OFS_CTL, 32'h0);
    wr(OFS_BMR, {30'h0, MR_CAPT});
    wr(OFS_BILR, 32'hA);
    wr(OFS_BMTCH, 32'h6);
    wr(OFS_CTL, 32'hD00);
    SRC.pulses(1, 1);
    SRC.step(1, 1'b1);
    rd(OFS_RIS);
    `CHK(d[9], 1'b0)
    SRC.step(1, 1'b0);
    rd(OFS_RIS);
    `CHK(d[9], 1'b1)
    SRC.step(1, 1'b1);
    rd(OFS_CTL);
    `CHK(d[8], 1'b0)
    rd(OFS_BCNT);
    `CHK(d, 32'hA)
    SRC.step(1, 1'b0);
    // Waveform on half A; prescale must not stretch the period
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'hFFFF);
    wr(OFS_AMR, 32'hA);
    wr(OFS_AILR, 32'h9);
    wr(OFS_AMTCH, 32'h2);
    wr(OFS_APR, 32'h3);
    wr(OFS_CTL, 32'h1);
    duty(14);
    wr(OFS_CTL, 32'h0);
    wr(OFS_CTL, 32'h41);
    duty(6);
    wr(OFS_AILR, 32'h4);
    duty(12);
    #1 `CHK({ccp_oe, ccp_out[1]}, 3'b010)
    rd(OFS_RIS);
    `CHK(d, 32'h0)
    // Clock counter: 1 up to match 3, then rolls to 0
    wr(OFS_CTL, 32'h0);
    wr(OFS_AMR, {30'h0, MR_PERIOD});
    wr(OFS_CFG, {29'h0, CFG_RTC});
    wr(OFS_AMTCH, 32'h3);
    wr(OFS_IMR, 32'h8);
    wr(OFS_CTL, 32'h11);
    poll(3, 1);
    rd(OFS_ACNT);
    `CHK(d, 32'h0)
    wr(OFS_ICR, 32'h8);
    rd(OFS_MIS);
    `CHK(d[3], 1'b0)
    // Reset in mid-run
    do_reset();
    rd(OFS_CFG);
    `CHK(d, 32'h0)
    summarize();
  end
endmodule // testbench
